//--- rtl/tpcs_defs.vh
`ifndef TPCS_DEFS_VH
`define TPCS_DEFS_VH

// memory map selections
`define TPCS_MAP_SELECT_TWO    4'h2
`define TPCS_MAP_SELECT_THREE  4'h3

// register offsets
`define TPCS_OFS_PKG_ONE       16'h0005
`define TPCS_OFS_PKG_TWO       16'h0006
`define TPCS_OFS_EXT_ABILITY   16'h0012
`define TPCS_OFS_CONTROL       16'h08f3
`define TPCS_OFS_STATUS        16'h08f4
`define TPCS_OFS_JABBER_CNT    16'h08f5
`define TPCS_OFS_COLLISION_CNT 16'h08f6

// control fields
`define TPCS_CTRL_SOFT_RESET   15
`define TPCS_CTRL_LOOPBACK     14
// status fields
`define TPCS_STAT_FAULT        7

// constant register values
`define TPCS_PKG_ONE_VALUE     16'h000b
`define TPCS_PKG_TWO_VALUE     16'h0000
`define TPCS_EXT_ABILITY_VALUE 16'h0008
`define TPCS_ZERO16            16'h0000
`define TPCS_UPPER_ZERO        16'h0000
`define TPCS_ZERO32            32'h0000_0000

// counter saturation value and soft reset length
`define TPCS_CNT_MAX           16'hffff
`define TPCS_RST_CYCLES        16

`endif

//--- rtl/tpcs_sat_counter.v
`timescale 1ns/1ps
`default_nettype none
`include "tpcs_defs.vh"

module tpcs_sat_counter #(
  parameter CNT_W = 16
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             sys_rst,
  // control
  input  wire             inc,
  input  wire             clr,
  // count
  output reg  [CNT_W-1:0] count
);

  wire at_max;

  assign at_max = (count == `TPCS_CNT_MAX);

  always @(posedge core_clk) begin
    if (sys_rst) begin
      count <= `TPCS_ZERO16;
    end else if (clr) begin
      // event in the clearing cycle is kept, not lost
      count <= inc ? {{(CNT_W-1){1'b0}}, 1'b1} : `TPCS_ZERO16; // RULE6 RULE7
    end else if (inc && !at_max) begin // RULE8
      count <= count + {{(CNT_W-1){1'b0}}, 1'b1}; // RULE6 RULE7
    end
  end

endmodule // tpcs_sat_counter
`default_nettype wire

//--- rtl/tpcs_mmd_regs.v
// Summary of operation
// RULE1 - writing one to control bit 15 returns coding registers to defaults
// RULE2 - soft reset resets coding and attachment layers, bit self-clears after
// RULE3 - control bit 14 loops MAC data through transmit and receive coding
// RULE4 - status bit 7 sets on local or remote jabber fault
// RULE5 - fault bit stays latched until status read; the read clears it
// RULE6 - 16-bit remote jabber counter counts events, clears on read
// RULE7 - 16-bit physical collision counter counts collisions, clears on read
// RULE8 - both counters saturate at 0xFFFF until read
// RULE9 - logical collisions from arbitration never count as physical ones
// RULE10 - package presence one reads bits 3, 1, 0 set, rest zero
// RULE11 - extended ability reads bit 3 set only, rest zero
// RULE12 - every register here is 16 bits wide
// RULE13 - accesses are 32 bits; upper half reads zero, writes ignored
// RULE14 - zero bits and read-only registers ignore writes, no side effect
`timescale 1ns/1ps
`default_nettype none
`include "tpcs_defs.vh"

module tpcs_mmd_regs #(
  parameter RST_CYCLES = `TPCS_RST_CYCLES,
  parameter CNT_W      = 16
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        sys_rst,
  // register access from the serial protocol engine
  input  wire [3:0]  acc_map_sel,
  input  wire [15:0] acc_addr,
  input  wire        acc_wr,
  input  wire        acc_rd,
  input  wire [31:0] acc_wdata,
  output reg  [31:0] acc_rdata,
  output reg         acc_ack,
  output reg         acc_err,
  // coding sublayer events
  input  wire        jabber_local,
  input  wire        jabber_remote,
  input  wire        collision_seen,
  input  wire        collision_logical,
  // control toward the datapath
  output reg         loopback_en,
  output reg         coding_reset,
  output reg         medium_reset
);

  // register indices
  localparam [2:0] IDX_NONE = 3'd0;
  localparam [2:0] IDX_PKG1 = 3'd1;
  localparam [2:0] IDX_PKG2 = 3'd2;
  localparam [2:0] IDX_EXT  = 3'd3;
  localparam [2:0] IDX_CTRL = 3'd4;
  localparam [2:0] IDX_STAT = 3'd5;
  localparam [2:0] IDX_JAB  = 3'd6;
  localparam [2:0] IDX_COL  = 3'd7;

  // soft reset states
  localparam [0:0] ST_RUN = 1'b0;
  localparam [0:0] ST_RST = 1'b1;

  // full-width difference first, then cut to the counter width on purpose
  localparam [31:0] RST_LAST_W = RST_CYCLES - 1;
  localparam [15:0] RST_LAST   = RST_LAST_W[15:0];

  // decode of map selection and offset, shared by read and write
  function [2:0] reg_index;
    input [3:0]  map_sel;
    input [15:0] addr;
    begin
      reg_index = IDX_NONE;
      if (map_sel == `TPCS_MAP_SELECT_TWO) begin
        case (addr)
          `TPCS_OFS_CONTROL:       reg_index = IDX_CTRL;
          `TPCS_OFS_STATUS:        reg_index = IDX_STAT;
          `TPCS_OFS_JABBER_CNT:    reg_index = IDX_JAB;
          `TPCS_OFS_COLLISION_CNT: reg_index = IDX_COL;
          default:                 reg_index = IDX_NONE;
        endcase
      end else if (map_sel == `TPCS_MAP_SELECT_THREE) begin
        case (addr)
          `TPCS_OFS_PKG_ONE:     reg_index = IDX_PKG1;
          `TPCS_OFS_PKG_TWO:     reg_index = IDX_PKG2;
          `TPCS_OFS_EXT_ABILITY: reg_index = IDX_EXT;
          default:               reg_index = IDX_NONE;
        endcase
      end
    end
  endfunction

  reg  [0:0]       state;
  reg  [0:0]       next_state;
  reg  [15:0]      rst_cnt;
  reg  [15:0]      next_rst_cnt;
  reg              fault;
  reg              next_fault;
  reg              next_loopback_en;
  reg  [15:0]      rd_value;
  wire [2:0]       acc_idx;
  wire             rd_go;
  wire             wr_go;
  wire             in_reset;
  wire             start_reset;
  wire             evt_ok;
  wire             jab_clr;
  wire             col_clr;
  wire             col_real;
  wire [CNT_W-1:0] jab_count;
  wire [CNT_W-1:0] col_count;

  assign acc_idx  = reg_index(acc_map_sel, acc_addr);
  // a read and write in one cycle is taken as a read only
  assign rd_go    = acc_rd;
  assign wr_go    = acc_wr && !acc_rd;
  assign in_reset = (state == ST_RST);
  // upper half of the write word is never looked at
  assign start_reset = wr_go && (acc_idx == IDX_CTRL) && !in_reset &&
                       acc_wdata[`TPCS_CTRL_SOFT_RESET]; // RULE1 RULE13
  // events are dropped while the coding layer is held in reset
  assign evt_ok   = !in_reset;
  // arbitration-made collisions carry no superposition on the wire
  assign col_real = collision_seen && !collision_logical && evt_ok; // RULE9
  assign jab_clr  = in_reset || (rd_go && (acc_idx == IDX_JAB)); // RULE1 RULE6
  assign col_clr  = in_reset || (rd_go && (acc_idx == IDX_COL)); // RULE1 RULE7

  // soft reset sequencer
  always @* begin
    next_state   = state;
    next_rst_cnt = rst_cnt;
    case (state)
      ST_RUN: begin
        next_rst_cnt = `TPCS_ZERO16;
        if (start_reset) begin
          next_state = ST_RST; // RULE2
        end
      end
      ST_RST: begin
        if (rst_cnt == RST_LAST) begin
          next_state   = ST_RUN; // RULE2
          next_rst_cnt = `TPCS_ZERO16;
        end else begin
          next_rst_cnt = rst_cnt + 16'h0001;
        end
      end
      default: begin
        next_state   = ST_RUN;
        next_rst_cnt = `TPCS_ZERO16;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      state        <= ST_RUN;
      rst_cnt      <= `TPCS_ZERO16;
      coding_reset <= 1'b0;
      medium_reset <= 1'b0;
    end else begin
      state        <= next_state;
      rst_cnt      <= next_rst_cnt;
      // both layers held while the sequence runs
      coding_reset <= (next_state == ST_RST); // RULE2
      medium_reset <= (next_state == ST_RST); // RULE2
    end
  end

  // loopback control
  always @* begin
    next_loopback_en = loopback_en;
    if (start_reset || in_reset) begin
      next_loopback_en = 1'b0; // RULE1
    end else if (wr_go && (acc_idx == IDX_CTRL)) begin
      next_loopback_en = acc_wdata[`TPCS_CTRL_LOOPBACK]; // RULE3
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      loopback_en <= 1'b0;
    end else begin
      loopback_en <= next_loopback_en; // RULE3
    end
  end

  // latched jabber fault
  always @* begin
    next_fault = fault;
    if (in_reset) begin
      next_fault = 1'b0; // RULE1
    end else if (jabber_local || jabber_remote) begin
      // set wins over a read in the same cycle
      next_fault = 1'b1; // RULE4
    end else if (rd_go && (acc_idx == IDX_STAT)) begin
      next_fault = 1'b0; // RULE5
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      fault <= 1'b0;
    end else begin
      fault <= next_fault;
    end
  end

  // diagnostic counters
  tpcs_sat_counter #(
    .CNT_W (CNT_W)
  ) u_remote_jabber_tally (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .inc      (jabber_remote && evt_ok), // RULE6
    .clr      (jab_clr),
    .count    (jab_count)
  );

  tpcs_sat_counter #(
    .CNT_W (CNT_W)
  ) u_physical_collision_tally (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .inc      (col_real), // RULE7
    .clr      (col_clr),
    .count    (col_count)
  );

  // read multiplexer, every register 16 bits wide
  always @* begin
    rd_value = `TPCS_ZERO16;
    case (acc_idx)
      IDX_PKG1: rd_value = `TPCS_PKG_ONE_VALUE; // RULE10 RULE12
      IDX_PKG2: rd_value = `TPCS_PKG_TWO_VALUE; // RULE12
      IDX_EXT:  rd_value = `TPCS_EXT_ABILITY_VALUE; // RULE11 RULE12
      IDX_CTRL: begin
        // bit 15 reads one until the sequence finishes
        rd_value[`TPCS_CTRL_SOFT_RESET] = in_reset; // RULE2
        rd_value[`TPCS_CTRL_LOOPBACK]   = loopback_en; // RULE3
      end
      IDX_STAT: rd_value[`TPCS_STAT_FAULT] = fault; // RULE5
      IDX_JAB:  rd_value = jab_count[15:0]; // RULE6
      IDX_COL:  rd_value = col_count[15:0]; // RULE7
      default:  rd_value = `TPCS_ZERO16;
    endcase
  end

  // answer one cycle after the access
  always @(posedge core_clk) begin
    if (sys_rst) begin
      acc_rdata <= `TPCS_ZERO32;
      acc_ack   <= 1'b0;
      acc_err   <= 1'b0;
    end else begin
      acc_ack <= rd_go || wr_go;
      acc_err <= (rd_go || wr_go) && (acc_idx == IDX_NONE); // RULE14
      if (rd_go) begin
        acc_rdata <= {`TPCS_UPPER_ZERO, rd_value}; // RULE13
      end else begin
        acc_rdata <= `TPCS_ZERO32;
      end
    end
  end

  // writes to constant, status and counter registers store nothing
  // and clear nothing; only a read has side effects there (RULE14)

endmodule // tpcs_mmd_regs
`default_nettype wire

//--- test/tpcs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tpcs_host_model (
  // clock
  input  wire logic        core_clk,
  // access request
  output var  logic [3:0]  acc_map_sel,
  output var  logic [15:0] acc_addr,
  output var  logic        acc_wr,
  output var  logic        acc_rd,
  output var  logic [31:0] acc_wdata,
  // answer
  input  wire logic [31:0] acc_rdata,
  input  wire logic        acc_ack,
  input  wire logic        acc_err
);
  initial begin
    {acc_map_sel, acc_addr, acc_wr, acc_rd, acc_wdata} = 54'h0;
  end
  // one whole word per access, strobe for one cycle
  task automatic xfer(input logic w, input logic [3:0] m,
    input logic [15:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic [1:0] st);
    @(negedge core_clk);
    {acc_map_sel, acc_addr, acc_wdata} = {m, a, d};
    {acc_wr, acc_rd} = {w, !w};
    @(negedge core_clk);
    {acc_wr, acc_rd} = 2'h0;
    // stale address and data would hide decode slips
    {acc_addr, acc_wdata} = ~{a, d};
    q = acc_rdata;
    st = {acc_ack, acc_err};
  endtask
endmodule // tpcs_host_model
`default_nettype wire

//--- test/tpcs_mmd_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpcs_defs.vh"
module tpcs_mmd_regs_chk #(
  parameter RST_CYCLES = 16
) (
  // clock, reset, access
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [3:0]  acc_map_sel,
  input wire logic [15:0] acc_addr,
  input wire logic        acc_wr,
  input wire logic        acc_rd,
  input wire logic [31:0] acc_wdata,
  input wire logic [31:0] acc_rdata,
  input wire logic        acc_ack,
  input wire logic        acc_err,
  // control outputs
  input wire logic        loopback_en,
  input wire logic        coding_reset,
  input wire logic        medium_reset
);
  int rst_len = 0;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // counted here, too long to unroll
  always @(posedge core_clk) begin
    rst_len <= coding_reset ? rst_len + 1 : 0;
  end
  sequence s_ctl_wr;
    acc_wr && !acc_rd && !coding_reset && acc_addr == `TPCS_OFS_CONTROL
      && acc_map_sel == `TPCS_MAP_SELECT_TWO;
  endsequence
  sequence s_rd(a);
    acc_rd && acc_map_sel == `TPCS_MAP_SELECT_THREE && acc_addr == a;
  endsequence
  property p_ack; (acc_rd || acc_wr) |=> acc_ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_upper; acc_ack |-> acc_rdata[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper set");
  property p_err; acc_err |-> acc_ack && acc_rdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad refusal");
  property p_go;
    s_ctl_wr ##0 acc_wdata[15] |=> coding_reset && medium_reset
      && !loopback_en;
  endproperty
  a_go: assert property (p_go) else $error("no soft reset");
  property p_len; $fell(coding_reset) |-> rst_len == RST_CYCLES; endproperty
  a_len: assert property (p_len) else $error("reset length");
  property p_loop; s_ctl_wr ##0 acc_wdata[15:14] == 2'h1 |=> loopback_en;
  endproperty
  a_loop: assert property (p_loop) else $error("no loopback");
  property p_pkg;
    s_rd(`TPCS_OFS_PKG_ONE) |=> acc_rdata == 32'h0000_000b;
  endproperty
  a_pkg: assert property (p_pkg) else $error("presence value");
  property p_ext;
    s_rd(`TPCS_OFS_EXT_ABILITY) |=> acc_rdata == 32'h0000_0008;
  endproperty
  a_ext: assert property (p_ext) else $error("ability value");
endmodule // tpcs_mmd_regs_chk
bind tpcs_mmd_regs tpcs_mmd_regs_chk #(.RST_CYCLES(RST_CYCLES))
  u_tpcs_mmd_regs_chk (.*);
`default_nettype wire

//--- test/tpcs_mmd_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpcs_defs.vh"
module tpcs_mmd_regs_tb;
  logic             core_clk = 1'b0;
  logic             sys_rst = 1'b1;
  logic [3:0]       ev = 4'h0;
  wire logic [3:0]  acc_map_sel;
  wire logic [15:0] acc_addr;
  wire logic [31:0] acc_wdata, acc_rdata;
  wire logic        acc_wr, acc_rd, acc_ack, acc_err;
  wire logic        loopback_en, coding_reset, medium_reset;
  wire logic        jabber_local, jabber_remote;
  wire logic        collision_seen, collision_logical;
  wire logic [2:0]  ctl_out = {coding_reset, medium_reset, loopback_en};
  int               miscompares = 0;
  int               comparisons = 0;
  int               cycles = 0;
  localparam logic [3:0] m2 = `TPCS_MAP_SELECT_TWO;
  localparam logic [3:0] m3 = `TPCS_MAP_SELECT_THREE;
  assign {jabber_local, jabber_remote, collision_seen, collision_logical} = ev;
  // short soft reset keeps the run brief
  tpcs_mmd_regs #(.RST_CYCLES(2)) u_tpcs_mmd_regs (.*);
  tpcs_host_model u_tpcs_host_model (.*);
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 70000) begin
      miscompares = miscompares + 1;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [3:0] m, input logic [15:0] a,
    input logic [31:0] exp, input logic e = 1'b0);
    logic [31:0] q;
    logic [1:0]  st;
    u_tpcs_host_model.xfer(1'b0, m, a, 32'h0, q, st);
    chk({30'h0, st}, {30'h0, 1'b1, e});
    chk(q, exp);
  endtask
  task automatic wr(input logic [3:0] m, input logic [15:0] a,
    input logic [31:0] d);
    logic [31:0] q;
    logic [1:0]  st;
    u_tpcs_host_model.xfer(1'b1, m, a, d, q, st);
    chk({30'h0, st}, 32'h0000_0002);
  endtask
  task automatic pulse(input logic [3:0] v, input int n);
    @(negedge core_clk);
    ev = v;
    repeat (n) @(negedge core_clk);
    ev = 4'h0;
  endtask
  task automatic t_const();
    rd(m3, `TPCS_OFS_PKG_ONE, 32'h0000_000b);
    wr(m3, `TPCS_OFS_PKG_ONE, 32'hffff_fff4);
    rd(m3, `TPCS_OFS_PKG_ONE, 32'h0000_000b);
    rd(m3, `TPCS_OFS_PKG_TWO, 32'h0000_0000);
    rd(m3, `TPCS_OFS_EXT_ABILITY, 32'h0000_0008);
    rd(m2, `TPCS_OFS_PKG_ONE, 32'h0000_0000, 1'b1);
  endtask
  task automatic t_ctrl();
    wr(m2, `TPCS_OFS_CONTROL, 32'hffff_7fff);
    chk({29'h0, ctl_out}, 32'h0000_0001);
    rd(m2, `TPCS_OFS_CONTROL, 32'h0000_4000);
    wr(m2, `TPCS_OFS_CONTROL, 32'h0000_0000);
    chk({29'h0, ctl_out}, 32'h0000_0000);
  endtask
  task automatic t_events();
    pulse(4'h8, 1);
    rd(m2, `TPCS_OFS_STATUS, 32'h0000_0080);
    rd(m2, `TPCS_OFS_STATUS, 32'h0000_0000);
    pulse(4'h4, 3);
    wr(m2, `TPCS_OFS_JABBER_CNT, 32'h0000_0000);
    rd(m2, `TPCS_OFS_STATUS, 32'h0000_0080);
    rd(m2, `TPCS_OFS_JABBER_CNT, 32'h0000_0003);
    rd(m2, `TPCS_OFS_JABBER_CNT, 32'h0000_0000);
    pulse(4'h2, 4);
    pulse(4'h3, 2);
    rd(m2, `TPCS_OFS_COLLISION_CNT, 32'h0000_0004);
    rd(m2, `TPCS_OFS_COLLISION_CNT, 32'h0000_0000);
  endtask
  task automatic t_sat();
    pulse(4'h6, 65540);
    rd(m2, `TPCS_OFS_JABBER_CNT, 32'h0000_ffff);
    rd(m2, `TPCS_OFS_COLLISION_CNT, 32'h0000_ffff);
    pulse(4'h6, 3);
  endtask
  task automatic t_reset();
    wr(m2, `TPCS_OFS_CONTROL, 32'h0000_4000);
    wr(m2, `TPCS_OFS_CONTROL, 32'h0000_c000);
    chk({29'h0, ctl_out}, 32'h0000_0006);
    repeat (4) @(negedge core_clk);
    chk({29'h0, ctl_out}, 32'h0000_0000);
    rd(m2, `TPCS_OFS_CONTROL, 32'h0000_0000);
    rd(m2, `TPCS_OFS_STATUS, 32'h0000_0000);
    rd(m2, `TPCS_OFS_JABBER_CNT, 32'h0000_0000);
    rd(m2, `TPCS_OFS_COLLISION_CNT, 32'h0000_0000);
  endtask
  initial begin
    repeat (6) @(negedge core_clk);
    sys_rst = 1'b0;
    t_const();
    t_ctrl();
    t_events();
    t_sat();
    t_reset();
    give_verdict();
  end
endmodule // tpcs_mmd_regs_tb
`default_nettype wire
